// file: design/cps_port_select.sv
// Purpose: Decide pin ownership between configuration logic and user I/O, and run boot clock.
// Assumes: Options come from the stored row; boot data arrives as a serial bit stream.
// Notes: Ownership is frozen at user-mode entry; only the test enable pin stays live.
// Contract
// - Test option enabled keeps four test pins as boundary-scan in user mode.
// - Test option disabled: dynamic pin high gives scan, low gives I/O.
// - Dynamic enable pin is honoured only while the test option is disabled.
// - SPI pins become I/O only when slave and master SPI options disabled.
// - Slave SPI enabled keeps SPI pins attached for an external master.
// - Slave SPI disabled detaches pins but alone does not make them I/O.
// - Master SPI enabled boots external image, or dual-boot for internal placement.
// - Enabled or hard-only master SPI gives hardened controller the SPI pins.
// - External I2C access needs bus clock at least 7.5x the I2C rate.
// - I2C option disabled detaches I2C pins and makes them I/O.
// - Hardened I2C controllers are usable only with the I2C option enabled.
// - Status option disabled makes request, complete and init pins I/O.
// - Request-pin setting: low request pin reconfigures; others become I/O.
// - Complete-only, request-plus-complete and all-three keep their named pins.
// - Init-only setting keeps init and frees request and complete pins.
// - Warm reconfiguration via request pin unless another port can send refresh.
// - Boot fetch starts with a nominal 2.08 MHz master clock.
// - After padding and start word, next word sets new clock, switched shortly after.
// - New clock setting must stay between 2.08 and 133 MHz; code only raises 0 to 1, so divisors above 49 run below 2.08 MHz.
// - Port options persist in stored row; clock rate comes only from data.
module cps_port_select
    import cps_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input cps_options_t stored_options,
    input wire logic user_mode,
    input wire logic test_port_dynamic_enable,
    input wire logic reconfig_request_pin,
    input wire logic refresh_command,
    input wire logic boot_start,
    input wire logic boot_data_in,
    output cps_owner_t owner,
    output cps_boot_t boot_mode,
    output logic seamless_update_ready,
    output logic reconfig_start,
    output logic boot_clock,
    output logic [7:0] boot_clock_rate_value,
    output logic boot_clock_switched
);
    typedef enum logic [1:0] {
        CPS_BT_IDLE = 2'h0,
        CPS_BT_HUNT = 2'h1,
        CPS_BT_RATE = 2'h2,
        CPS_BT_RUN = 2'h3
    } cps_bt_state_t;

    cps_options_t latched;
    logic user_mode_q;
    logic dyn_en_sync;
    logic req_low_sync;
    logic req_low_q;
    cps_owner_t next_owner;
    cps_bt_state_t bt_state;
    logic [15:0] shift;
    logic [3:0] bit_count;
    logic [7:0] div_count;
    logic [7:0] div_value;
    logic [7:0] pending_div;
    logic [1:0] switch_count;
    logic clk_rise;

    cps_sync u_sync_dyn (
        .ref_clk(ref_clk),
        .reset(reset),
        .pin_in(test_port_dynamic_enable),
        .pin_sync(dyn_en_sync)
    );

    // Inverted ahead of the synchroniser, so its reset level matches the idle pin.
    // A sync that reset low against a high pin would fake a falling edge.
    cps_sync u_sync_req (
        .ref_clk(ref_clk),
        .reset(reset),
        .pin_in(!reconfig_request_pin),
        .pin_sync(req_low_sync)
    );

    // Latch options on the rising edge of user mode only, so a row write later has no effect.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            latched <= OPTIONS_RESET;
            user_mode_q <= 1'b0;
        end else begin
            user_mode_q <= user_mode;
            if (user_mode && !user_mode_q) begin
                latched <= stored_options;
            end
        end
    end

    always_comb begin
        next_owner = '0;
        if (user_mode_q) begin
            next_owner.test_port_config = latched.test_port_enable || dyn_en_sync;
            next_owner.slave_spi_attached = latched.slave_spi_enable;
            next_owner.hard_spi_access = latched.master_spi != CPS_MSPI_DISABLE;
            next_owner.spi_gpio = !latched.slave_spi_enable &&
                latched.master_spi == CPS_MSPI_DISABLE;
            next_owner.i2c_attached = latched.i2c_enable;
            next_owner.i2c_gpio = !latched.i2c_enable;
            next_owner.hard_i2c_usable = latched.i2c_enable;
            unique case (latched.status_pin_option)
                CPS_SDM_DISABLE: begin
                end
                CPS_SDM_REQUEST: next_owner.request_pin_config = 1'b1;
                CPS_SDM_COMPLETE: next_owner.complete_pin_config = 1'b1;
                CPS_SDM_INIT: next_owner.init_pin_config = 1'b1;
                CPS_SDM_REQ_COMPLETE: begin
                    next_owner.request_pin_config = 1'b1;
                    next_owner.complete_pin_config = 1'b1;
                end
                CPS_SDM_ALL: begin
                    next_owner.request_pin_config = 1'b1;
                    next_owner.complete_pin_config = 1'b1;
                    next_owner.init_pin_config = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            owner <= '0;
        end else begin
            owner <= next_owner;
        end
    end

    // The copy follows the latch, so it too is frozen for the rest of user mode.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            seamless_update_ready <= 1'b0;
        end else begin
            seamless_update_ready <= latched.seamless_update_option;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            boot_mode <= CPS_BOOT_NONE;
        end else begin
            if (latched.master_spi == CPS_MSPI_ENABLE) begin
                boot_mode <= latched.image_external ? CPS_BOOT_EXTERNAL : CPS_BOOT_DUAL;
            end else begin
                boot_mode <= CPS_BOOT_NONE;
            end
        end
    end

    // The refresh path only counts when an attached port could have delivered it.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            req_low_q <= 1'b0;
            reconfig_start <= 1'b0;
        end else begin
            req_low_q <= req_low_sync;
            reconfig_start <= user_mode_q && (
                (owner.request_pin_config && !req_low_q && req_low_sync) ||
                (refresh_command && (owner.test_port_config || owner.slave_spi_attached ||
                owner.i2c_attached)));
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            bt_state <= CPS_BT_IDLE;
            shift <= '0;
            bit_count <= '0;
            pending_div <= BOOT_DIV_RESET;
            div_value <= BOOT_DIV_RESET;
            switch_count <= '0;
            boot_clock_rate_value <= BOOT_DIV_RESET;
            boot_clock_switched <= 1'b0;
        end else begin
            unique case (bt_state)
                CPS_BT_IDLE: begin
                    div_value <= BOOT_DIV_RESET;
                    boot_clock_switched <= 1'b0;
                    if (boot_start && boot_mode != CPS_BOOT_NONE) begin
                        bt_state <= CPS_BT_HUNT;
                    end
                end
                CPS_BT_HUNT: begin
                    if (clk_rise) begin
                        shift <= {shift[14:0], boot_data_in};
                        if ({shift[14:0], boot_data_in} == START_WORD) begin
                            bt_state <= CPS_BT_RATE;
                            bit_count <= '0;
                        end
                    end
                end
                CPS_BT_RATE: begin
                    if (clk_rise) begin
                        shift <= {shift[14:0], boot_data_in};
                        bit_count <= bit_count + 4'h1;
                        if (bit_count == 4'h7) begin
                            // Zero is raised to BOOT_DIV_MIN, the fastest rate, so the reported rate never reads zero.
                            pending_div <= ({shift[6:0], boot_data_in} < BOOT_DIV_MIN) ?
                                BOOT_DIV_MIN : {shift[6:0], boot_data_in};
                            switch_count <= SWITCH_DELAY;
                            bt_state <= CPS_BT_RUN;
                        end
                    end
                end
                CPS_BT_RUN: begin
                    if (switch_count != 2'h0) begin
                        switch_count <= switch_count - 2'h1;
                        if (switch_count == 2'h1) begin
                            div_value <= pending_div;
                            boot_clock_rate_value <= pending_div;
                            boot_clock_switched <= 1'b1;
                        end
                    end
                    if (!boot_start) begin
                        bt_state <= CPS_BT_IDLE;
                    end
                end
                default: bt_state <= CPS_BT_IDLE;
            endcase
        end
    end

    // Odd divisors round down to an even period; one toggle per ref_clk is the ceiling.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            div_count <= '0;
            boot_clock <= 1'b0;
        end else if (bt_state == CPS_BT_IDLE) begin
            div_count <= '0;
            boot_clock <= 1'b0;
        end else if (div_count + 8'h1 >= (div_value >> 1) || div_value == BOOT_DIV_MIN) begin
            div_count <= '0;
            boot_clock <= !boot_clock;
        end else begin
            div_count <= div_count + 8'h1;
        end
    end

    assign clk_rise = (bt_state != CPS_BT_IDLE) && !boot_clock &&
        (div_count + 8'h1 >= (div_value >> 1) || div_value == BOOT_DIV_MIN);

endmodule // cps_port_select

// file: common/cps_pkg.sv
// Purpose: Shared constants and types for the configuration-port ownership block.
// Assumes: One 100 MHz clock, synchronous active-high reset.
// Notes: Option encodings are stored values, latched at entry to user mode.
package cps_pkg;

    localparam int unsigned CLK_FREQ_KHZ = 100000;

    typedef enum logic [1:0] {
        CPS_MSPI_DISABLE = 2'h0,
        CPS_MSPI_ENABLE = 2'h1,
        CPS_MSPI_HARD_ONLY = 2'h2
    } cps_mspi_t;

    typedef enum logic [2:0] {
        CPS_SDM_DISABLE = 3'h0,
        CPS_SDM_REQUEST = 3'h1,
        CPS_SDM_COMPLETE = 3'h2,
        CPS_SDM_INIT = 3'h3,
        CPS_SDM_REQ_COMPLETE = 3'h4,
        CPS_SDM_ALL = 3'h5
    } cps_sdm_t;

    typedef enum logic [1:0] {
        CPS_BOOT_NONE = 2'h0,
        CPS_BOOT_EXTERNAL = 2'h1,
        CPS_BOOT_DUAL = 2'h2
    } cps_boot_t;

    typedef struct packed {
        logic test_port_enable;
        logic slave_spi_enable;
        cps_mspi_t master_spi;
        logic i2c_enable;
        cps_sdm_t status_pin_option;
        logic image_external;
        logic seamless_update_option;
    } cps_options_t;

    localparam cps_options_t OPTIONS_RESET = '{
        test_port_enable: 1'b1,
        slave_spi_enable: 1'b0,
        master_spi: CPS_MSPI_DISABLE,
        i2c_enable: 1'b0,
        status_pin_option: CPS_SDM_DISABLE,
        image_external: 1'b0,
        seamless_update_option: 1'b0
    };

    typedef struct packed {
        logic test_port_config;
        logic spi_gpio;
        logic slave_spi_attached;
        logic hard_spi_access;
        logic i2c_attached;
        logic i2c_gpio;
        logic hard_i2c_usable;
        logic request_pin_config;
        logic complete_pin_config;
        logic init_pin_config;
    } cps_owner_t;

    // Boot clock divider: 100 MHz / 48 = 2.083 MHz nominal start-up rate.
    localparam logic [7:0] BOOT_DIV_RESET = 8'h30;
    localparam logic [7:0] BOOT_DIV_MIN = 8'h01;
    localparam logic [15:0] START_WORD = 16'hbdb3;
    localparam logic [1:0] SWITCH_DELAY = 2'h2;

endpackage

// file: design/cps_sync.sv
// Purpose: Two-flip-flop synchroniser for pin inputs.
// Assumes: Input is asynchronous to ref_clk.
// Notes: The first stage feeds only the second stage.
module cps_sync (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic pin_in,
    output logic pin_sync
);
    logic stage1;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            stage1 <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            stage1 <= pin_in;
            pin_sync <= stage1;
        end
    end
endmodule // cps_sync

// file: test/cps_flash_model.sv
// Purpose: Serial boot flash at the far side of the boot interface.
// Assumes: Data changes on the falling boot clock, the sampler uses the rising one.
// Notes: Past the image the line replays it inverted, so a stale bit never looks valid.
module cps_flash_model
    import cps_pkg::*;
#(
    parameter logic [7:0] DIV = 8'h04
)
(
    input wire logic ref_clk,
    input wire logic boot_start,
    input wire logic boot_clock,
    output logic boot_data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [39:0] sh = '1;
    logic prev = 1'b0;
    assign boot_data_in = sh[39];
    always_ff @(posedge ref_clk) begin
        prev <= boot_clock;
        if (!boot_start) begin
            sh <= {16'hffff, 16'hbdb3, DIV};
        end else if (prev && !boot_clock) begin
            sh <= {sh[38:0], ~sh[39]};
        end
    end
endmodule // cps_flash_model

// file: test/cps_port_select_monitor.sv
// Purpose: Ownership and boot clock checks at the port-select ports.
// Assumes: Ownership settles two edges after user-mode entry.
// Notes: User-mode ownership and boot-mode checks wait until the entry latch has settled.
module cps_port_select_monitor
    import cps_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input cps_options_t stored_options,
    input wire logic user_mode,
    input wire logic test_port_dynamic_enable,
    input wire logic boot_start,
    input cps_owner_t owner,
    input cps_boot_t boot_mode,
    input wire logic boot_clock,
    input wire logic boot_clock_switched
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt;
    logic [7:0] per;
    logic pbc, seen;
    cps_options_t lt;
    wire cps_sdm_t s = lt.status_pin_option;
    wire logic ok = user_mode && cnt >= 2'h2;
    wire logic rise = boot_clock && !pbc;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    always_ff @(posedge ref_clk) begin
        cnt <= (reset || !user_mode) ? 2'h0 : cnt + {1'b0, cnt != 2'h3};
        if (reset) lt <= OPTIONS_RESET;
        else if (user_mode && cnt == 2'h0) lt <= stored_options;
    end
    always_ff @(posedge ref_clk) begin
        pbc <= boot_clock;
        per <= rise ? 8'h01 : per + {7'h0, per != 8'hff};
        seen <= boot_start && !reset && (seen || rise);
    end
    property p_tp_on; ok && lt.test_port_enable |-> owner.test_port_config; endproperty
    a_tp_on: assert property (p_tp_on) else $error("test port dropped");
    property p_tp_dyn;
        (ok && !lt.test_port_enable && $stable(test_port_dynamic_enable)) [*6]
            |-> owner.test_port_config == test_port_dynamic_enable;
    endproperty
    a_tp_dyn: assert property (p_tp_dyn) else $error("dynamic enable wrong");
    property p_spi_io;
        ok |-> owner.spi_gpio == (!lt.slave_spi_enable && lt.master_spi == CPS_MSPI_DISABLE);
    endproperty
    a_spi_io: assert property (p_spi_io) else $error("spi io wrong");
    property p_slave; ok |-> owner.slave_spi_attached == lt.slave_spi_enable; endproperty
    a_slave: assert property (p_slave) else $error("slave spi wrong");
    property p_hard; ok |-> owner.hard_spi_access == (lt.master_spi != CPS_MSPI_DISABLE); endproperty
    a_hard: assert property (p_hard) else $error("hard spi wrong");
    property p_i2c;
        ok |-> owner.i2c_attached == lt.i2c_enable && owner.i2c_gpio != lt.i2c_enable
            && owner.hard_i2c_usable == lt.i2c_enable;
    endproperty
    a_i2c: assert property (p_i2c) else $error("i2c wrong");
    property p_stat;
        ok |-> owner.request_pin_config == (s inside {CPS_SDM_REQUEST, CPS_SDM_REQ_COMPLETE,
            CPS_SDM_ALL}) && owner.init_pin_config == (s inside {CPS_SDM_INIT, CPS_SDM_ALL})
            && owner.complete_pin_config == (s inside {CPS_SDM_COMPLETE, CPS_SDM_REQ_COMPLETE,
            CPS_SDM_ALL});
    endproperty
    a_stat: assert property (p_stat) else $error("status pin wrong");
    property p_idle; !user_mode [*3] |-> owner == '0; endproperty
    a_idle: assert property (p_idle) else $error("owner outside user mode");
    property p_boot;
        ok |-> boot_mode == (lt.master_spi != CPS_MSPI_ENABLE ? CPS_BOOT_NONE
            : lt.image_external ? CPS_BOOT_EXTERNAL : CPS_BOOT_DUAL);
    endproperty
    a_boot: assert property (p_boot) else $error("boot mode wrong");
    property p_rate; rise && seen && !boot_clock_switched |-> per == 8'h30; endproperty
    a_rate: assert property (p_rate) else $error("start-up period wrong");
endmodule // cps_port_select_monitor
bind cps_port_select cps_port_select_monitor i_mon (.ref_clk(ref_clk), .reset(reset),
    .stored_options(stored_options), .user_mode(user_mode), .boot_start(boot_start),
    .test_port_dynamic_enable(test_port_dynamic_enable), .owner(owner),
    .boot_mode(boot_mode), .boot_clock(boot_clock), .boot_clock_switched(boot_clock_switched));

// file: test/tb.sv
// Purpose: Self-checking bench for the configuration-port ownership block.
// Assumes: The flash model feeds the boot stream.
// Notes: Rows cover every master SPI and status-pin code.
module tb
    import cps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        cps_options_t opt;
        cps_owner_t own;
    } cps_row_t;
    localparam logic [7:0] DIV = 8'h04;
    localparam cps_row_t ROWS [6] = '{{10'h200, 10'h310}, {10'h125, 10'h0ac},
        {10'h24a, 10'h252}, {10'h18c, 10'h0d1}, {10'h230, 10'h32e}, {10'h075, 10'h06f}};
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    cps_options_t opts = OPTIONS_RESET;
    logic um = 1'b0, dyn = 1'b0, req_pin = 1'b1, refresh = 1'b0, bstart = 1'b0;
    logic boot_data, rstart, bclk, switched, seam;
    cps_owner_t own;
    cps_boot_t bmode;
    logic [7:0] rate;
    int n_errors = 0, cmp_count = 0;
    bit seen;
    always #5 ref_clk = ~ref_clk;
    cps_port_select i_dut (.ref_clk(ref_clk), .reset(reset), .stored_options(opts),
        .user_mode(um), .test_port_dynamic_enable(dyn), .reconfig_request_pin(req_pin),
        .refresh_command(refresh), .boot_start(bstart), .boot_data_in(boot_data),
        .owner(own), .boot_mode(bmode), .seamless_update_ready(seam),
        .reconfig_start(rstart), .boot_clock(bclk), .boot_clock_rate_value(rate),
        .boot_clock_switched(switched));
    cps_flash_model #(.DIV(DIV)) i_flash (.ref_clk(ref_clk), .boot_start(bstart),
        .boot_clock(bclk), .boot_data_in(boot_data));
    task automatic check(string what, logic [15:0] got, logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("Checks %0d, errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic look();
        @(negedge ref_clk);
    endtask
    // The second option set lands mid user mode and must be ignored.
    task automatic enter(cps_options_t o, cps_options_t alt);
        cyc(1);
        opts <= o;
        um <= 1'b1;
        cyc(4);
        opts <= alt;
        cyc(2);
    endtask
    task automatic pulse();
        seen = 1'b0;
        repeat (10) begin
            look();
            seen |= (rstart === 1'b1);
        end
        cyc(1);
    endtask
    initial begin
        cps_boot_t eb;
        cyc(10);
        reset <= 1'b0;
        cyc(1);
        look();
        check("reset owner", own, 16'h0);
        check("reset rate", rate, 16'h30);
        foreach (ROWS[i]) begin
            enter(ROWS[i].opt, ROWS[5 - i].opt);
            look();
            eb = ROWS[i].opt.image_external ? CPS_BOOT_EXTERNAL : CPS_BOOT_DUAL;
            if (ROWS[i].opt.master_spi != CPS_MSPI_ENABLE) eb = CPS_BOOT_NONE;
            check("owner", own, ROWS[i].own);
            check("seamless", seam, ROWS[i].opt.seamless_update_option);
            check("boot mode", bmode, eb);
            cyc(1);
            um <= 1'b0;
            cyc(4);
            look();
            check("idle owner", own, 16'h0);
        end
        enter(ROWS[2].opt, ROWS[3].opt);
        refresh <= 1'b1;
        cyc(1);
        refresh <= 1'b0;
        pulse();
        check("refresh restart", seen, 1'b1);
        req_pin <= 1'b0;
        pulse();
        check("unkept pin restart", seen, 1'b0);
        req_pin <= 1'b1;
        um <= 1'b0;
        // Master SPI boot with the request pin kept and no second SPI master.
        enter(ROWS[5].opt, ROWS[4].opt);
        bstart <= 1'b1;
        repeat (6000) if (switched !== 1'b1) cyc(1);
        look();
        check("switched", switched, 1'b1);
        check("new rate", rate, DIV);
        cyc(1);
        reset <= 1'b1;
        bstart <= 1'b0;
        um <= 1'b0;
        cyc(2);
        reset <= 1'b0;
        cyc(1);
        look();
        check("rerun owner", own, 16'h0);
        check("rerun rate", rate, BOOT_DIV_RESET);
        check("rerun switched", switched, 1'b0);
        enter(ROWS[1].opt, ROWS[0].opt);
        dyn <= 1'b1;
        cyc(8);
        look();
        check("scan owner", own.test_port_config, 1'b1);
        cyc(1);
        req_pin <= 1'b0;
        pulse();
        check("pin restart", seen, 1'b1);
        final_report();
    end
    initial begin
        #100000;
        n_errors++;
        $display("MISMATCH watchdog expected finish seen hang");
        final_report();
    end
endmodule // tb
